// ===== logic/adcal_ctrl.v
// calibration and successive-approximation control of a 16-bit sampling converter
//
// Functional notes
// - a high CAL resets the internal logic at once, without a clock, and forces BUSY high.
// - a high CAL aborts any conversion or calibration already in progress.
// - calibration starts when CAL falls and ends after 85,532 clocks with BUSY going low.
// - SAMPLE high during calibration puts meaningless diagnostic bits on SERIAL_OUT.
// - the first step ties the input to the ground sense input and stores the offset.
// - nine mismatch steps measure the top nine bit capacitors and store each correction.
// - every later conversion subtracts the stored offset and mismatch corrections.
// - a calibration request is taken at any time whatever the block is doing.
// - results come from a bit-by-bit search and are 16 bits wide.
// - the held value is the input one aperture delay after SAMPLE falls.
// - BUSY is high whenever a conversion or a calibration is in progress.
// - outside calibration a falling SAMPLE edge starts a conversion.
`timescale 1ns/1ps
`include "adcal_regs.vh"
module adcal_ctrl #(
  parameter integer CAL_CYCLES = `ADCAL_CAL_CYCLES
) (
  input  wire        CLK,
  input  wire        RST_N,
  input  wire        CAL,
  input  wire        SAMPLE,
  input  wire        COMP,
  output reg         BUSY,
  output reg         HOLD,
  output reg         GND_SENSE_SEL,
  output reg         CAP_TEST,
  output reg  [3:0]  CAP_SEL,
  output reg  [15:0] DAC_CODE,
  output reg  [15:0] RESULT,
  output reg         RESULT_VALID,
  output reg         SERIAL_OUT
);
  // calibration steps reuse the conversion states; in_cal tells them apart

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_APER = 2'h1;
  localparam [1:0] ST_SAR  = 2'h2;
  localparam [1:0] ST_DONE = 2'h3;

  localparam integer APER_LAST = `ADCAL_APER_CYC - 1;
  localparam integer CAL_LAST  = CAL_CYCLES - 1;

  // one-hot weight of a search bit, used to set and to clear trial bits
  function [15:0] bit_mask;
    input [3:0] idx;
    begin
      bit_mask = 16'h0001 << idx;
    end
  endfunction

  reg  [1:0]  st;
  reg         in_cal;
  reg  [3:0]  step;
  reg  [3:0]  bit_idx;
  reg  [15:0] code;
  reg  [15:0] acc;
  reg  [1:0]  aper_cnt;
  reg  [16:0] cal_cnt;
  reg         sample_q;
  reg  [15:0] shift;
  reg         mem_we;
  reg  [3:0]  mem_waddr;
  reg  [15:0] mem_wdata;

  wire [15:0] mem_rdata;
  wire [4:0]  next_corr;
  wire [3:0]  mem_raddr;
  wire [15:0] kept_code;
  wire [15:0] next_trial;
  wire [15:0] corrected;
  wire        sample_fall;
  wire        int_rst_n;

  // CAL acts as a second asynchronous reset of everything below except the correction memory
  // a glitch on CAL restarts the whole run, so the host must keep that pin clean
  assign int_rst_n   = RST_N & ~CAL;
  assign sample_fall = sample_q & ~SAMPLE;

  // read address runs one bit ahead so the word is registered in time for the decision
  assign next_corr = 5'h11 - {1'b0, bit_idx};
  assign mem_raddr = (st == ST_APER) ? `ADCAL_FIRST_CAP :
                     ((st == ST_SAR) && (bit_idx >= `ADCAL_CORR_NEXT)) ? next_corr[3:0] :
                     `ADCAL_OFS_ADDR;

  assign kept_code = COMP ? code : (code & ~bit_mask(bit_idx));
  // decided bits plus the trial bit of the next position
  assign next_trial = kept_code | bit_mask(bit_idx - 4'h1);
  // in the finishing cycle the memory presents the offset word
  assign corrected = code - acc - mem_rdata;

  adcal_mem u_mem (
    .clk   (CLK),
    .we    (mem_we),
    .waddr (mem_waddr),
    .wdata (mem_wdata),
    .raddr (mem_raddr),
    .rdata (mem_rdata)
  );

  always @(posedge CLK or negedge int_rst_n) begin
    if (!int_rst_n) begin
      // leaving reset always enters the offset step of a calibration run
      st            <= ST_APER;
      in_cal        <= 1'b1;
      step          <= 4'h0;
      bit_idx       <= 4'h0;
      code          <= 16'h0000;
      acc           <= 16'h0000;
      aper_cnt      <= 2'h0;
      cal_cnt       <= 17'h00000;
      sample_q      <= 1'b0;
      shift         <= 16'h0000;
      mem_we        <= 1'b0;
      mem_waddr     <= 4'h0;
      mem_wdata     <= 16'h0000;
      BUSY          <= 1'b1;
      HOLD          <= 1'b0;
      GND_SENSE_SEL <= 1'b1;
      CAP_TEST      <= 1'b0;
      CAP_SEL       <= 4'h0;
      DAC_CODE      <= 16'h0000;
      RESULT        <= 16'h0000;
      RESULT_VALID  <= 1'b0;
      SERIAL_OUT    <= 1'b0;
    end else begin
      sample_q     <= SAMPLE;
      mem_we       <= 1'b0;
      RESULT_VALID <= 1'b0;

      // 17 bits hold the full run length; the count stops once the run is over
      if (in_cal) begin
        cal_cnt <= cal_cnt + 17'h00001;
      end

      // diagnostic bits replace the result stream while calibrating with SAMPLE high
      if (in_cal && SAMPLE) begin
        SERIAL_OUT <= code[bit_idx];
      end else begin
        SERIAL_OUT <= shift[15];
      end
      shift <= {shift[14:0], 1'b0};

      case (st)
        ST_IDLE: begin
          if (in_cal) begin
            // the measuring steps finish early; BUSY waits for the full run length
            if (cal_cnt == CAL_LAST[16:0]) begin
              in_cal <= 1'b0;
              BUSY   <= 1'b0;
            end
          end else if (sample_fall) begin
            st       <= ST_APER;
            aper_cnt <= 2'h0;
            BUSY     <= 1'b1;
          end
        end
        ST_APER: begin
          if (aper_cnt == APER_LAST[1:0]) begin
            HOLD     <= 1'b1;
            st       <= ST_SAR;
            bit_idx  <= `ADCAL_TOP_BIT;
            code     <= bit_mask(`ADCAL_TOP_BIT);
            DAC_CODE <= bit_mask(`ADCAL_TOP_BIT);
            acc      <= 16'h0000;
          end else begin
            aper_cnt <= aper_cnt + 2'h1;
          end
        end
        ST_SAR: begin
          // a kept upper bit adds its capacitor correction
          if (!in_cal && COMP && (bit_idx >= `ADCAL_CORR_LOW)) begin
            acc <= acc + mem_rdata;
          end
          if (bit_idx == 4'h0) begin
            code     <= kept_code;
            DAC_CODE <= kept_code;
            st       <= ST_DONE;
          end else begin
            code     <= next_trial;
            DAC_CODE <= next_trial;
            bit_idx  <= bit_idx - 4'h1;
          end
        end
        ST_DONE: begin
          HOLD <= 1'b0;
          if (in_cal) begin
            // step 0 is the ground-sense offset, steps 1..9 the capacitor mismatches
            mem_we        <= 1'b1;
            mem_waddr     <= step;
            mem_wdata     <= code;
            GND_SENSE_SEL <= 1'b0;
            if (step != `ADCAL_CAP_STEPS) begin
              step     <= step + 4'h1;
              CAP_TEST <= 1'b1;
              CAP_SEL  <= step;
              aper_cnt <= 2'h0;
              st       <= ST_APER;
            end else begin
              CAP_TEST <= 1'b0;
              st       <= ST_IDLE;
            end
          end else begin
            RESULT       <= corrected;
            RESULT_VALID <= 1'b1;
            shift        <= corrected;
            BUSY         <= 1'b0;
            st           <= ST_IDLE;
          end
        end
        default: begin
          st <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// ===== logic/adcal_regs.vh
// constants shared by the calibration and conversion sequencer
`ifndef ADCAL_REGS_VH
`define ADCAL_REGS_VH
`define ADCAL_CAL_CYCLES  85532
`define ADCAL_CLK_NS      20
`define ADCAL_APER_NS     40
`define ADCAL_APER_CYC    ((`ADCAL_APER_NS + `ADCAL_CLK_NS - 1) / `ADCAL_CLK_NS)
`define ADCAL_CAP_STEPS   4'h9
`define ADCAL_OFS_ADDR    4'h0
`define ADCAL_FIRST_CAP   4'h1
`define ADCAL_CORR_LOW    4'h7
`define ADCAL_CORR_NEXT   4'h8
`define ADCAL_TOP_BIT     4'hF
`define ADCAL_MEM_DEPTH   10
`endif

// ===== logic/adcal_mem.v
// correction memory: offset word and nine capacitor mismatch words
`timescale 1ns/1ps
module adcal_mem (
  input  wire        clk,
  input  wire        we,
  input  wire [3:0]  waddr,
  input  wire [15:0] wdata,
  input  wire [3:0]  raddr,
  output reg  [15:0] rdata
);
  `include "adcal_regs.vh"

  // no reset: contents are meaningless until a calibration run has stored them
  reg [15:0] mem [0:`ADCAL_MEM_DEPTH-1];

  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule

// ===== tb/adcal_chk_asserts.sv
// port checker for the calibration and conversion sequencer
`timescale 1ns/1ps
module adcal_chk #(
  parameter integer CAL_CYCLES = 85532
) (
  input wire        CLK,
  input wire        RST_N,
  input wire        CAL,
  input wire        SAMPLE,
  input wire        BUSY,
  input wire        HOLD,
  input wire        GND_SENSE_SEL,
  input wire        CAP_TEST,
  input wire [3:0]  CAP_SEL,
  input wire [15:0] RESULT,
  input wire        RESULT_VALID,
  input wire        SERIAL_OUT
);
  // edges since the last release; saturates so later traffic keeps it quiet
  integer cnt;
  always @(posedge CLK or negedge RST_N or posedge CAL) begin
    if (!RST_N || CAL) cnt <= 0;
    else if (cnt <= CAL_CYCLES) cnt <= cnt + 1;
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  sequence s_go; !BUSY && !CAL && $past(SAMPLE) && !SAMPLE; endsequence
  property p_cal_busy; CAL |-> BUSY; endproperty
  a_cal_busy: assert property (p_cal_busy) else $error("busy low under cal");
  property p_abort; CAL |-> !HOLD && !RESULT_VALID && !CAP_TEST; endproperty
  a_abort: assert property (p_abort) else $error("activity under cal");
  property p_run; cnt < CAL_CYCLES |-> BUSY; endproperty
  a_run: assert property (p_run) else $error("busy dropped in run");
  property p_end; cnt == CAL_CYCLES |-> $fell(BUSY); endproperty
  a_end: assert property (p_end) else $error("run length wrong");
  property p_gnd; cnt < 10 |-> GND_SENSE_SEL && !CAP_TEST; endproperty
  a_gnd: assert property (p_gnd) else $error("offset step not first");
  property p_msb; $rose(CAP_TEST) |-> CAP_SEL == 4'h0; endproperty
  a_msb: assert property (p_msb) else $error("first mismatch step not top bit");
  property p_nine; $fell(CAP_TEST) && !CAL |-> CAP_SEL == 4'h8; endproperty
  a_nine: assert property (p_nine) else $error("mismatch step count wrong");
  property p_start; s_go |=> BUSY; endproperty
  a_start: assert property (p_start) else $error("no conversion start");
  property p_aper; s_go |=> !HOLD [*2] ##1 HOLD; endproperty
  a_aper: assert property (p_aper) else $error("aperture wrong");
  property p_len; disable iff (!RST_N || CAL) s_go |-> ##19 BUSY ##1 (!BUSY && RESULT_VALID);
  endproperty
  a_len: assert property (p_len) else $error("conversion length wrong");
  property p_ser; disable iff (!RST_N || CAL)
    RESULT_VALID |=> SERIAL_OUT == RESULT[15] ##1 SERIAL_OUT == RESULT[14]; endproperty
  a_ser: assert property (p_ser) else $error("serial order wrong");
endmodule
bind adcal_ctrl adcal_chk #(.CAL_CYCLES(CAL_CYCLES)) u_chk (
  .CLK(CLK), .RST_N(RST_N), .CAL(CAL), .SAMPLE(SAMPLE), .BUSY(BUSY), .HOLD(HOLD),
  .GND_SENSE_SEL(GND_SENSE_SEL), .CAP_TEST(CAP_TEST), .CAP_SEL(CAP_SEL), .RESULT(RESULT),
  .RESULT_VALID(RESULT_VALID), .SERIAL_OUT(SERIAL_OUT)
);

// ===== tb/adcal_comp_model.sv
// comparator model: judges each trial code against the level in use
`timescale 1ns/1ps
module adcal_comp_model #(
  parameter [15:0] OFS = 16'h0010,
  parameter [15:0] MIS = 16'h0003
) (
  input  wire        gnd_sel,
  input  wire        cap_test,
  input  wire [15:0] code,
  input  wire [15:0] level,
  output wire        comp
);
  // every capacitor shows the same mismatch, so each stored correction equals MIS
  assign comp = code <= (cap_test ? MIS : (gnd_sel ? OFS : level));
endmodule

// ===== tb/adcal_ctrl_tb.sv
// self-checking bench for the calibration sequencer
`timescale 1ns/1ps
module adcal_ctrl_tb;
  localparam integer CC  = 300;
  localparam [15:0]  OFS = 16'h0010;
  localparam [15:0]  MIS = 16'h0003;
  reg         clk = 1'b0, rst_n = 1'b0, cal = 1'b0, sample = 1'b0;
  reg  [15:0] vin = 16'h0000;
  wire        comp, busy, hold, gnd, cap_test, result_valid, serial_out;
  wire [15:0] code, result;
  wire [3:0]  cap_sel;
  integer     fails = 0, n_compared = 0, cyc = 0;
  adcal_ctrl #(.CAL_CYCLES(CC)) dut (.CLK(clk), .RST_N(rst_n), .CAL(cal), .SAMPLE(sample),
    .COMP(comp), .BUSY(busy), .HOLD(hold), .GND_SENSE_SEL(gnd), .CAP_TEST(cap_test),
    .CAP_SEL(cap_sel), .DAC_CODE(code), .RESULT(result), .RESULT_VALID(result_valid),
    .SERIAL_OUT(serial_out));
  adcal_comp_model #(.OFS(OFS), .MIS(MIS)) cmp (.gnd_sel(gnd), .cap_test(cap_test), .code(code),
    .level(vin), .comp(comp));
  initial forever #10 clk = ~clk;
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task step;
    @(posedge clk) #1;
  endtask
  task end_of_test;
    begin
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask
  // diag says whether SAMPLE is high during the run, so diagnostic bits must show
  task wait_cal(input diag);
    integer n, ones, ct;
    reg [3:0] last_sel;
    begin
      n = 0;
      ones = 0;
      ct = 0;
      last_sel = 4'h0;
      while (busy && n < 2 * CC) begin
        step;
        n = n + 1;
        if (serial_out === 1'b1) ones = ones + 1;
        if (cap_test === 1'b1) begin
          ct = ct + 1;
          last_sel = cap_sel;
        end
      end
      chk(n[15:0], CC);
      chk({15'h0000, ones != 0}, {15'h0000, diag});
      // nine mismatch steps of 2 aperture, 16 search and 1 store cycles
      chk(ct[15:0], 16'h00AB);
      chk({12'h000, last_sel}, 16'h0008);
    end
  endtask
  // kept counts the upper nine bits the search keeps, each costing one MIS correction
  task conv(input [15:0] v, input [3:0] kept);
    integer i;
    reg [15:0] s;
    reg [15:0] want;
    begin
      want = v - OFS - kept * MIS;
      vin = v;
      sample = 1'b1;
      step;
      sample = 1'b0;
      i = 0;
      while (result_valid !== 1'b1 && i < 30) begin
        step;
        i = i + 1;
      end
      chk(i[15:0], 16'h0014);
      chk(result, want);
      for (i = 15; i >= 0; i = i - 1) begin
        step;
        s[i] = serial_out;
      end
      chk(s, want);
    end
  endtask
  // calibrate request in mid-search, then a run with sample left high
  task t_abort;
    begin
      vin = 16'h8001;
      sample = 1'b1;
      step;
      sample = 1'b0;
      repeat (6) step;
      cal = 1'b1;
      #2;
      chk({15'h0000, hold}, 16'h0000);
      chk({14'h0000, busy, gnd}, 16'h0003);
      step;
      sample = 1'b1;
      step;
      cal = 1'b0;
      wait_cal(1'b1);
    end
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      fails = fails + 1;
      end_of_test;
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    #1 rst_n = 1'b1;
    wait_cal(1'b0);
    conv(16'h1234, 4'h2);
    conv(16'hFFFF, 4'h9);
    t_abort;
    conv(16'h0010, 4'h0);
    end_of_test;
  end
endmodule
